//--- design/ermc_ctrl.sv
// emergency-run mode controller with ahb-lite registers
// assumes the designated input is a raw field pin and the key pulse is
// synchronous to sys_clk; drive faults and commands come from on-chip logic
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module ermc_ctrl #(
    parameter int AR_CYC = ermc_pkg::ERMC_AR_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // field side
    input wire logic designated_input_line,
    input wire logic halt_key,
    output logic indication_output_line,
    // drive core side
    input wire logic [15:0] speed_ref_in,
    input wire logic run_cmd_in,
    input wire logic general_enable_in,
    input wire logic [7:0] fault_in,
    output logic [15:0] speed_ref_out,
    output logic run_cmd_out,
    output logic pulse_enable,
    output logic [7:0] fault_out,
    output logic crit_fault_reset,
    output logic [15:0] emergency_alarm_code,
    output logic [3:0] operating_state_param,
    output logic irq
);
    typedef struct packed {
        logic [1:0] din_sync;
        logic active;
        logic alarm_shown;
        logic [15:0] sel;
        logic ar_sel;
        logic [7:0] limit;
        logic [15:0] max_spd;
        logic [2:0] irq_st;
        logic [2:0] irq_msk;
        logic [31:0] log_cnt;
        logic [7:0] ar_count;
        logic [27:0] ar_tmr;
        logic ar_wait;
        logic ar_pulse;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } ermc_state_t;

    ermc_state_t s_r, s_nxt;

    // a selection that arms the function; 0 and reserved 3 do not
    function automatic logic ermc_armed(input logic [15:0] sel);
        ermc_armed = (sel == ermc_pkg::ERMC_SEL_ALARM) ||
            (sel == ermc_pkg::ERMC_SEL_MAXSPD) ||
            (sel == ermc_pkg::ERMC_SEL_COAST);
    endfunction

    logic din_open;
    logic crit_seen;
    logic ar_allowed;
    logic [2:0] ev;
    logic rd_hit;
    logic rd_req;

    assign din_open = ~s_r.din_sync[1];
    assign crit_seen = s_r.active && |(fault_in & ermc_pkg::ERMC_CRIT_MASK);
    // limited policy counts resets against the normal limit
    assign ar_allowed = s_r.ar_sel || (s_r.ar_count < s_r.limit);
    assign rd_hit = s_r.ap_valid && !s_r.ap_write;
    assign rd_req = hsel && hready && htrans[1] && !hwrite;

    // next-state logic: sync, mode, bus, auto-reset, log
    always_comb begin
        s_nxt = s_r;
        ev = '0;
        // two-stage sync; only the second stage is read
        s_nxt.din_sync = {s_r.din_sync[0], designated_input_line};
        // enter on open when armed, leave only on close
        if (!s_r.active && din_open && ermc_armed(s_r.sel)) begin
            s_nxt.active = 1'b1;
            s_nxt.alarm_shown = 1'b1;
            s_nxt.log_cnt = s_r.log_cnt + 32'h1;
            ev[ermc_pkg::ERMC_IRQ_ENTER] = 1'b1;
        end else if (s_r.active && !din_open) begin
            s_nxt.active = 1'b0;
            s_nxt.alarm_shown = 1'b0;
            s_nxt.ar_count = '0;
            s_nxt.ar_wait = 1'b0;
            ev[ermc_pkg::ERMC_IRQ_EXIT] = 1'b1;
        end else if (s_r.active && halt_key) begin
            s_nxt.alarm_shown = 1'b0;
        end
        // critical fault auto-reset, one second after detection
        s_nxt.ar_pulse = 1'b0;
        if (crit_seen && !s_r.ar_wait && ar_allowed) begin
            s_nxt.ar_wait = 1'b1;
            s_nxt.ar_tmr = '0;
            ev[ermc_pkg::ERMC_IRQ_CRIT] = 1'b1;
        end else if (s_r.ar_wait && s_r.active) begin
            if (s_r.ar_tmr == ermc_pkg::ERMC_AR_CNT_W'(AR_CYC - 1)) begin
                s_nxt.ar_wait = 1'b0;
                s_nxt.ar_pulse = 1'b1;
                if (!s_r.ar_sel && s_r.ar_count != 8'hFF) begin
                    s_nxt.ar_count = s_r.ar_count + 8'h1;
                end
            end else begin
                s_nxt.ar_tmr = s_r.ar_tmr + 28'h1;
            end
        end
        // a wait left from a closed period must not leak into the next one
        if (!s_nxt.active) begin
            s_nxt.ar_wait = 1'b0;
        end
        // bus data phase; a read of the interrupt status word clears it, set wins
        s_nxt.irq_st = s_r.irq_st;
        if (s_r.ap_valid && s_r.ap_write) begin
            case (s_r.ap_addr)
                ermc_pkg::ERMC_SEL_OFS: s_nxt.sel = hwdata[15:0];
                ermc_pkg::ERMC_ARSEL_OFS: s_nxt.ar_sel = hwdata[0];
                ermc_pkg::ERMC_LIMIT_OFS: s_nxt.limit = hwdata[7:0];
                ermc_pkg::ERMC_MAXSPD_OFS: s_nxt.max_spd = hwdata[15:0];
                ermc_pkg::ERMC_IRQMSK_OFS: s_nxt.irq_msk = hwdata[2:0];
                default: ;
            endcase
        end
        if (rd_hit && s_r.ap_addr == ermc_pkg::ERMC_IRQST_OFS) begin
            s_nxt.irq_st = '0;
        end
        s_nxt.irq_st = s_nxt.irq_st | ev;
        // address phase capture
        s_nxt.ap_valid = hsel && hready && htrans[1];
        s_nxt.ap_write = hwrite;
        s_nxt.ap_addr = haddr[7:0];
        s_nxt.rdata = '0;
        if (rd_req) begin
            case (haddr[7:0])
                ermc_pkg::ERMC_SEL_OFS: s_nxt.rdata = {16'h0, s_r.sel};
                ermc_pkg::ERMC_ARSEL_OFS: s_nxt.rdata = {31'h0, s_r.ar_sel};
                ermc_pkg::ERMC_LIMIT_OFS: s_nxt.rdata = {24'h0, s_r.limit};
                ermc_pkg::ERMC_MAXSPD_OFS: s_nxt.rdata = {16'h0, s_r.max_spd};
                ermc_pkg::ERMC_STATUS_OFS:
                    s_nxt.rdata = {28'h0, s_r.ar_wait, s_r.alarm_shown,
                        din_open, s_r.active};
                ermc_pkg::ERMC_IRQST_OFS: s_nxt.rdata = {29'h0, s_r.irq_st};
                ermc_pkg::ERMC_IRQMSK_OFS: s_nxt.rdata = {29'h0, s_r.irq_msk};
                ermc_pkg::ERMC_LOG_OFS: s_nxt.rdata = s_r.log_cnt;
                ermc_pkg::ERMC_KEY_OFS: s_nxt.rdata = {24'h0, s_r.ar_count};
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    // state register; the log counter has no write path at all
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.din_sync <= 2'b11;
            s_r.sel <= ermc_pkg::ERMC_SEL_RST;
            s_r.limit <= ermc_pkg::ERMC_LIMIT_RST;
            s_r.max_spd <= ermc_pkg::ERMC_MAXSPD_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign irq = |(s_r.irq_st & s_r.irq_msk);

    // drive core overrides
    assign indication_output_line = s_r.active;
    assign speed_ref_out = (s_r.active && s_r.sel == ermc_pkg::ERMC_SEL_MAXSPD)
        ? s_r.max_spd : speed_ref_in;
    // stop requests and general enable ignored while active
    assign run_cmd_out = s_r.active | (run_cmd_in & general_enable_in);
    assign pulse_enable = s_r.active
        ? (s_r.sel != ermc_pkg::ERMC_SEL_COAST)
        : general_enable_in;
    // ordinary faults masked, critical ones pass
    assign fault_out = s_r.active
        ? (fault_in & ermc_pkg::ERMC_CRIT_MASK) : fault_in;
    assign crit_fault_reset = s_r.ar_pulse;
    assign emergency_alarm_code = s_r.alarm_shown
        ? ermc_pkg::ERMC_ALARM_CODE : 16'h0000;
    assign operating_state_param = s_r.active
        ? ermc_pkg::ERMC_OPST_EMERG : ermc_pkg::ERMC_OPST_NORMAL;

    // checks
    a_off_no_entry: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.sel == ermc_pkg::ERMC_SEL_OFF) && !s_r.active |=> !s_r.active)
        else $error("entered mode while off");
    a_rsvd_no_entry: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.sel == ermc_pkg::ERMC_SEL_RSVD) && !s_r.active |=> !s_r.active)
        else $error("entered mode on reserved");
    a_alarm_on_entry: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s_r.active) |-> emergency_alarm_code == ermc_pkg::ERMC_ALARM_CODE)
        else $error("alarm missing on entry");
    a_speed_forced: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.active && s_r.sel == ermc_pkg::ERMC_SEL_MAXSPD
        |-> speed_ref_out == s_r.max_spd)
        else $error("speed not forced");
    a_coast_pulses: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.active && s_r.sel == ermc_pkg::ERMC_SEL_COAST |-> !pulse_enable)
        else $error("pulses on in coast");
    a_key_clears: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.active && halt_key && din_open |=>
        emergency_alarm_code == 16'h0000 &&
        operating_state_param == ermc_pkg::ERMC_OPST_EMERG)
        else $error("key did not clear alarm");
    a_output_tracks: assert property (@(posedge sys_clk) disable iff (rst)
        indication_output_line == s_r.active)
        else $error("indication wrong");
    a_stop_ignored: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.active && !general_enable_in |-> run_cmd_out)
        else $error("stop honoured in mode");
    a_faults_masked: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.active |-> (fault_out & ~ermc_pkg::ERMC_CRIT_MASK) == 8'h00)
        else $error("ordinary fault passed");
    a_crit_pass: assert property (@(posedge sys_clk) disable iff (rst)
        fault_out[1:0] == fault_in[1:0])
        else $error("critical fault lost");
    a_log_counts: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s_r.active) |-> s_r.log_cnt == $past(s_r.log_cnt) + 32'h1)
        else $error("period not logged");
    a_exit_on_close: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(s_r.active) |-> !$past(din_open))
        else $error("left mode while open");
    a_ar_delay: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.ar_pulse |-> $past(s_r.ar_wait))
        else $error("reset without wait");

    // outside the mode the run command is passed through, gated by the general enable
    a_normal_run: assert property (@(posedge sys_clk) disable iff (rst)
        !s_r.active |-> run_cmd_out == (run_cmd_in & general_enable_in))
        else $error("run command altered in normal mode");

    // outside the mode every fault reaches the core
    a_normal_faults: assert property (@(posedge sys_clk) disable iff (rst)
        !s_r.active |-> fault_out == fault_in)
        else $error("fault masked in normal mode");

    // outside the mode the general enable gates the pulses again
    a_normal_pulses: assert property (@(posedge sys_clk) disable iff (rst)
        !s_r.active |-> pulse_enable == general_enable_in)
        else $error("pulses altered in normal mode");

    // outside the mode the speed reference is never overridden
    a_normal_speed: assert property (@(posedge sys_clk) disable iff (rst)
        !s_r.active |-> speed_ref_out == speed_ref_in)
        else $error("speed altered in normal mode");

    // no stop request can end the mode while the contact stays open
    a_stay_while_open: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.active && din_open |=> s_r.active)
        else $error("mode left while input open");

    // only the max-speed selection touches the reference
    a_speed_kept: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.active && s_r.sel != ermc_pkg::ERMC_SEL_MAXSPD
        |-> speed_ref_out == speed_ref_in)
        else $error("speed changed without max selection");

    // general enable low must not stop the pulses unless coasting
    a_pulses_kept: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.active && s_r.sel != ermc_pkg::ERMC_SEL_COAST |-> pulse_enable)
        else $error("pulses stopped in mode");

    // entry needs an open contact seen through the synchroniser
    a_enter_open: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s_r.active) |-> $past(din_open))
        else $error("entered with input closed");

    // entry needs an arming selection; 0, 3 and unknown codes never arm
    a_enter_armed: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s_r.active) |-> ermc_armed($past(s_r.sel)))
        else $error("entered on a non-arming selection");

    // the log moves only on entry, so software cannot wipe it
    a_log_steady: assert property (@(posedge sys_clk) disable iff (rst)
        !$rose(s_r.active) |-> $stable(s_r.log_cnt))
        else $error("log changed outside entry");

    // entry is always reported to software
    a_enter_irq: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s_r.active) |-> s_r.irq_st[ermc_pkg::ERMC_IRQ_ENTER])
        else $error("entry not flagged");

    // exit is always reported to software
    a_exit_irq: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(s_r.active) |-> s_r.irq_st[ermc_pkg::ERMC_IRQ_EXIT])
        else $error("exit not flagged");

    // the fault reset is a single-cycle strobe
    a_reset_single: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.ar_pulse |=> !s_r.ar_pulse)
        else $error("fault reset held too long");

    // auto-reset only acts for faults raised inside the mode
    a_reset_when_act: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.ar_pulse |-> $past(s_r.active))
        else $error("fault reset outside mode");

    // limited policy starts no wait once the limit is used up
    a_limit_kept: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s_r.ar_wait) && !$past(s_r.ar_sel)
        |-> $past(s_r.ar_count) < $past(s_r.limit))
        else $error("auto-reset past limit");

    // the wait timer never runs beyond its terminal count
    a_timer_bound: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.ar_wait |-> s_r.ar_tmr <= ermc_pkg::ERMC_AR_CNT_W'(AR_CYC - 1))
        else $error("auto-reset timer overran");

    // read data stands only in the data phase of a read
    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rd_req) |-> hrdata == 32'h0000_0000)
        else $error("read data outside data phase");

    // no pending fault reset survives the end of the mode
    a_no_wait_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !s_r.active |-> !s_r.ar_wait)
        else $error("auto-reset wait left pending");

    // once cleared by the key the alarm stays off for the period
    a_alarm_stays_off: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.active && !s_r.alarm_shown |=> !s_r.alarm_shown)
        else $error("alarm shown again in period");

    // no alarm at all while the mode is off
    a_alarm_off_norm: assert property (@(posedge sys_clk) disable iff (rst)
        !s_r.active |-> emergency_alarm_code == 16'h0000)
        else $error("alarm outside mode");

    // each critical fault that starts a wait is flagged
    a_crit_irq: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s_r.ar_wait) |-> s_r.irq_st[ermc_pkg::ERMC_IRQ_CRIT])
        else $error("critical fault not flagged");
endmodule

//--- design/ermc_pkg.sv
// package for the emergency-run mode controller: register map, codes, timing
// assumes a 200 MHz sys_clk and an ahb-lite register bus of 32-bit words
package ermc_pkg;
    // byte offsets of the register words
    localparam logic [7:0] ERMC_SEL_OFS = 8'h00;
    localparam logic [7:0] ERMC_ARSEL_OFS = 8'h04;
    localparam logic [7:0] ERMC_LIMIT_OFS = 8'h08;
    localparam logic [7:0] ERMC_MAXSPD_OFS = 8'h0C;
    localparam logic [7:0] ERMC_STATUS_OFS = 8'h10;
    localparam logic [7:0] ERMC_IRQST_OFS = 8'h14;
    localparam logic [7:0] ERMC_IRQMSK_OFS = 8'h18;
    localparam logic [7:0] ERMC_LOG_OFS = 8'h1C;
    localparam logic [7:0] ERMC_KEY_OFS = 8'h20;
    // reset values
    localparam logic [15:0] ERMC_SEL_RST = 16'h0000;
    localparam logic [7:0] ERMC_LIMIT_RST = 8'h03;
    localparam logic [15:0] ERMC_MAXSPD_RST = 16'h0000;
    // selection codes
    localparam logic [15:0] ERMC_SEL_OFF = 16'h0000;
    localparam logic [15:0] ERMC_SEL_ALARM = 16'h0001;
    localparam logic [15:0] ERMC_SEL_MAXSPD = 16'h0002;
    localparam logic [15:0] ERMC_SEL_RSVD = 16'h0003;
    localparam logic [15:0] ERMC_SEL_COAST = 16'h0004;
    // operating state parameter codes
    localparam logic [3:0] ERMC_OPST_NORMAL = 4'h0;
    localparam logic [3:0] ERMC_OPST_EMERG = 4'h1;
    // alarm code reported while shown, an arbitrary numbering
    localparam logic [15:0] ERMC_ALARM_CODE = 16'h00D3;
    // interrupt bits: entry, exit, critical fault
    localparam int ERMC_IRQ_W = 3;
    localparam int ERMC_IRQ_ENTER = 0;
    localparam int ERMC_IRQ_EXIT = 1;
    localparam int ERMC_IRQ_CRIT = 2;
    // fault vector layout: bit 0 overvoltage, bit 1 overcurrent
    localparam int ERMC_FLT_W = 8;
    localparam logic [7:0] ERMC_CRIT_MASK = 8'h03;
    // one-second auto-reset delay in sys_clk cycles
    localparam int ERMC_CLK_MHZ = 200;
    localparam int ERMC_AR_DELAY_MS = 1000;
    localparam int ERMC_AR_CYC = ERMC_AR_DELAY_MS * 1000 * ERMC_CLK_MHZ;
    localparam int ERMC_AR_CNT_W = 28;
    localparam logic [1:0] ERMC_HTRANS_NONSEQ = 2'b10;
endpackage

//--- dv/ermc_field_model.sv
// field wiring and keypad model: the mode contact and the halt key
// assumes sys_clk is the controller clock; the contact idles closed
`timescale 1ns/10ps
module ermc_field_model (
    // clock
    input wire logic sys_clk,
    // field lines toward the controller
    output logic designated_input_line,
    output logic halt_key
);
    // idle: contact closed, key released
    initial begin
        designated_input_line = 1'b1;
        halt_key = 1'b0;
    end

    // contact opens to ask for the mode; no bounce is modelled
    task automatic open_line();
        @(posedge sys_clk);
        designated_input_line <= 1'b0;
    endtask

    // contact closes again
    task automatic close_line();
        @(posedge sys_clk);
        designated_input_line <= 1'b1;
    endtask

    // one-cycle key press, shortest the keypad can give
    task automatic press_halt();
        @(posedge sys_clk);
        halt_key <= 1'b1;
        @(posedge sys_clk);
        halt_key <= 1'b0;
    endtask
endmodule

//--- dv/testbench.sv
// bench for the emergency-run controller: ahb-lite tasks and mode tests
// assumes the field model drives pin and key; expectations from the package
`timescale 1ns/10ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] spd_in = 16'h1234;
    logic run_in = 1'b1;
    logic gen_en = 1'b1;
    logic [7:0] flt_in = 8'h00;
    logic hreadyout, hresp, ind, key, pin, run_out, pen, cfr, irq, seen;
    logic [31:0] hrdata, rd;
    logic [15:0] spd_out, alarm, s;
    logic [7:0] flt_out;
    logic [3:0] opst;
    int errors = 0;
    int comparisons = 0;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    ermc_field_model i_field (.sys_clk(sys_clk),
        .designated_input_line(pin), .halt_key(key));

    // short auto-reset delay keeps the run brief
    ermc_ctrl #(.AR_CYC(20)) i_dut (.sys_clk(sys_clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .designated_input_line(pin), .halt_key(key),
        .indication_output_line(ind), .speed_ref_in(spd_in),
        .run_cmd_in(run_in), .general_enable_in(gen_en), .fault_in(flt_in),
        .speed_ref_out(spd_out), .run_cmd_out(run_out),
        .pulse_enable(pen), .fault_out(flt_out), .crit_fault_reset(cfr),
        .emergency_alarm_code(alarm), .operating_state_param(opst),
        .irq(irq));

    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bounded wait for a sampled-high hready; a hang ends the run
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            errors++;
            conclude();
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= ermc_pkg::ERMC_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        check("hresp", 32'h0, hresp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        check(nm, e, rd);
    endtask

    // bounded wait on the indication line or the reset pulse
    task automatic wait_sig(input logic which, input logic v);
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while ((which ? cfr : ind) !== v && k < 60);
        check(which ? "crit_reset" : "indication", v, which ? cfr : ind);
        // a wait that ran out ends the run here
        if ((which ? cfr : ind) !== v) begin
            conclude();
        end
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rchk("sel", ermc_pkg::ERMC_SEL_OFS, 32'h0);
        rchk("limit", ermc_pkg::ERMC_LIMIT_OFS, 32'h3);
        wr(8'h40, 32'hFFFF);
        rchk("unmapped", 8'h40, 32'h0);
        // off and reserved selections must ignore the pin
        for (int i = 0; i < 2; i++) begin
            wr(ermc_pkg::ERMC_SEL_OFS, i ? 32'h3 : 32'h0);
            i_field.open_line();
            repeat (8) @(posedge sys_clk);
            check("ind_off", 1'b0, ind);
            check("alarm_off", 16'h0, alarm);
            i_field.close_line();
            repeat (4) @(posedge sys_clk);
        end
        wr(ermc_pkg::ERMC_IRQMSK_OFS, 32'h7);
        wr(ermc_pkg::ERMC_MAXSPD_OFS, 32'hABCD);
        wr(ermc_pkg::ERMC_ARSEL_OFS, 32'h1);
        // each active selection, with a stop request and faults pending
        for (int i = 0; i < 3; i++) begin
            s = i == 0 ? ermc_pkg::ERMC_SEL_ALARM : i == 1 ?
                ermc_pkg::ERMC_SEL_MAXSPD : ermc_pkg::ERMC_SEL_COAST;
            wr(ermc_pkg::ERMC_SEL_OFS, {16'h0, s});
            gen_en <= 1'b0;
            flt_in <= 8'hF0;
            i_field.open_line();
            wait_sig(1'b0, 1'b1);
            check("alarm", ermc_pkg::ERMC_ALARM_CODE, alarm);
            check("speed", i == 1 ? 16'hABCD : spd_in, spd_out);
            check("pulse", s != ermc_pkg::ERMC_SEL_COAST, pen);
            check("run", 1'b1, run_out);
            check("faults", 8'h00, flt_out);
            check("irq", 1'b1, irq);
            rchk("log", ermc_pkg::ERMC_LOG_OFS, i + 1);
            rchk("irq_enter", ermc_pkg::ERMC_IRQST_OFS, 32'h1);
            i_field.press_halt();
            repeat (2) @(posedge sys_clk);
            check("alarm_halt", 16'h0, alarm);
            check("opst", ermc_pkg::ERMC_OPST_EMERG, opst);
            rchk("status", ermc_pkg::ERMC_STATUS_OFS, 32'h3);
            i_field.close_line();
            wait_sig(1'b0, 1'b0);
            check("run_exit", 1'b0, run_out);
            check("faults_exit", 8'hF0, flt_out);
            check("opst_exit", ermc_pkg::ERMC_OPST_NORMAL, opst);
            rchk("irq_exit", ermc_pkg::ERMC_IRQST_OFS, 32'h2);
            // the clear lands at the data-phase edge, look one cycle on
            @(posedge sys_clk);
            check("irq_clr", 1'b0, irq);
            gen_en <= 1'b1;
            flt_in <= 8'h00;
        end
        // unlimited policy: more critical faults than the normal limit
        wr(ermc_pkg::ERMC_SEL_OFS, 32'h1);
        i_field.open_line();
        wait_sig(1'b0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            flt_in <= 8'h01;
            @(posedge sys_clk);
            check("crit_pass", 8'h01, flt_out);
            flt_in <= 8'h00;
            wait_sig(1'b1, 1'b1);
        end
        // unlimited resets are not counted against the limit
        rchk("resets", ermc_pkg::ERMC_KEY_OFS, 32'h0);
        rchk("irq_crit", ermc_pkg::ERMC_IRQST_OFS, 32'h5);
        i_field.close_line();
        wait_sig(1'b0, 1'b0);
        // limited policy: the normal limit of resets, then none
        wr(ermc_pkg::ERMC_ARSEL_OFS, 32'h0);
        i_field.open_line();
        wait_sig(1'b0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            flt_in <= 8'h02;
            @(posedge sys_clk);
            check("crit_pass2", 8'h02, flt_out);
            flt_in <= 8'h00;
            if (i < 3) begin
                wait_sig(1'b1, 1'b1);
            end else begin
                seen = 1'b0;
                repeat (40) begin
                    @(posedge sys_clk);
                    seen = seen | cfr;
                end
                check("no_reset", 1'b0, seen);
            end
        end
        rchk("resets_lim", ermc_pkg::ERMC_KEY_OFS,
            {24'h0, ermc_pkg::ERMC_LIMIT_RST});
        i_field.close_line();
        wait_sig(1'b0, 1'b0);
        rchk("log_all", ermc_pkg::ERMC_LOG_OFS, 32'h5);
        conclude();
    end
endmodule
